// *** ycc_defines.vh ***
// Register map, reset presets and stream widths of the colour matrix
`ifndef YCC_DEFINES_VH
`define YCC_DEFINES_VH

`define YCC_IN_W 8
`define YCC_OUT_W 8
`define YCC_PROD_W 18
`define YCC_COEF_W 17
`define YCC_COEF_FRAC 16
`define YCC_YRAW_FRAC 6

`define YCC_HAS_CLIPPING 1
`define YCC_HAS_CLAMPING 1

`define YCC_OFF_CTRL 12'h000
`define YCC_OFF_STATUS 12'h004
`define YCC_OFF_RED_W 12'h008
`define YCC_OFF_BLUE_W 12'h00C
`define YCC_OFF_RED_SC 12'h010
`define YCC_OFF_BLUE_SC 12'h014
`define YCC_OFF_Y_OFS 12'h018
`define YCC_OFF_CR_OFS 12'h01C
`define YCC_OFF_BLUE_OFS 12'h020
`define YCC_OFF_Y_MAX 12'h024
`define YCC_OFF_Y_MIN 12'h028
`define YCC_OFF_C_MAX 12'h02C
`define YCC_OFF_C_MIN 12'h030

`define YCC_CTRL_ENABLE 0
`define YCC_STAT_BUSY 0
`define YCC_STAT_FRAMES_LSB 16

`define YCC_RST_CTRL 1'h1
`define YCC_RST_RED_W 17'h04C8C
`define YCC_RST_BLUE_W 17'h01D2F
`define YCC_RST_RED_SC 17'h0B688
`define YCC_RST_BLUE_SC 17'h09063
`define YCC_RST_Y_OFS 8'h10
`define YCC_RST_C_OFS 8'h80
`define YCC_RST_MAX 8'hF0
`define YCC_RST_MIN 8'h10

`endif

// *** ycc_matrix.v ***
// RGB to luma/chroma matrix datapath with APB coefficient registers
`include "ycc_defines.vh"

module ycc_matrix #(
  parameter HAS_CLIPPING = `YCC_HAS_CLIPPING,
  parameter HAS_CLAMPING = `YCC_HAS_CLAMPING
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Stream slave, RGB in
  input wire s_valid,
  output wire s_ready,
  input wire s_sof,
  input wire s_eol,
  input wire [`YCC_IN_W-1:0] s_red,
  input wire [`YCC_IN_W-1:0] s_green,
  input wire [`YCC_IN_W-1:0] s_blue,
  // Stream master, luma/chroma out
  output reg m_valid,
  input wire m_ready,
  output reg m_sof,
  output reg m_eol,
  output reg [`YCC_OUT_W-1:0] m_luma,
  output reg [`YCC_OUT_W-1:0] m_red_chroma,
  output reg [`YCC_OUT_W-1:0] m_blue_chroma
);

  localparam IW = `YCC_IN_W;
  localparam OW = `YCC_OUT_W;
  localparam CW = `YCC_COEF_W;
  localparam YF = `YCC_YRAW_FRAC;
  // product width 18
  // Rounded sum keeps product width minus two bits
  localparam YW = `YCC_PROD_W - 2;
  localparam CF = `YCC_COEF_FRAC;
  localparam SH1 = CF - YF;
  localparam SH2 = CF + YF;

  // ******************************************************
  // Register file
  // ******************************************************
  reg ctrl_enable_reg;
  reg [CW-1:0] luma_red_weight;
  reg [CW-1:0] luma_blue_weight;
  reg [CW-1:0] red_diff_scale_reg;
  reg [CW-1:0] blue_diff_scale_reg;
  reg [OW-1:0] luma_offset;
  reg [OW-1:0] red_chroma_offset;
  reg [OW-1:0] blue_chroma_offset;
  reg [OW-1:0] luma_upper_limit;
  reg [OW-1:0] luma_lower_limit;
  reg [OW-1:0] chroma_upper_limit;
  reg [OW-1:0] chroma_lower_limit;
  reg [15:0] frame_count_reg;

  wire setup_ph;
  wire wr_take;
  reg [31:0] rd_next;
  reg hit_next;
  wire pipe_busy;

  assign setup_ph = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite;

  always @*
  begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (paddr)
      `YCC_OFF_CTRL: rd_next[`YCC_CTRL_ENABLE] = ctrl_enable_reg;
      `YCC_OFF_STATUS:
      begin
        rd_next[`YCC_STAT_BUSY] = pipe_busy;
        rd_next[31:`YCC_STAT_FRAMES_LSB] = frame_count_reg;
      end
      `YCC_OFF_RED_W: rd_next[CW-1:0] = luma_red_weight;
      `YCC_OFF_BLUE_W: rd_next[CW-1:0] = luma_blue_weight;
      `YCC_OFF_RED_SC: rd_next[CW-1:0] = red_diff_scale_reg;
      `YCC_OFF_BLUE_SC: rd_next[CW-1:0] = blue_diff_scale_reg;
      `YCC_OFF_Y_OFS: rd_next[OW-1:0] = luma_offset;
      `YCC_OFF_CR_OFS: rd_next[OW-1:0] = red_chroma_offset;
      `YCC_OFF_BLUE_OFS: rd_next[OW-1:0] = blue_chroma_offset;
      `YCC_OFF_Y_MAX: rd_next[OW-1:0] = luma_upper_limit;
      `YCC_OFF_Y_MIN: rd_next[OW-1:0] = luma_lower_limit;
      `YCC_OFF_C_MAX: rd_next[OW-1:0] = chroma_upper_limit;
      `YCC_OFF_C_MIN: rd_next[OW-1:0] = chroma_lower_limit;
      default: hit_next = 1'b0;
    endcase
  end

  // One-cycle access phase: ready rises on the first access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~hit_next;
      if (setup_ph & ~pwrite)
        prdata <= rd_next;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_enable_reg <= `YCC_RST_CTRL;
      luma_red_weight <= `YCC_RST_RED_W;
      luma_blue_weight <= `YCC_RST_BLUE_W;
      red_diff_scale_reg <= `YCC_RST_RED_SC;
      blue_diff_scale_reg <= `YCC_RST_BLUE_SC;
      luma_offset <= `YCC_RST_Y_OFS;
      red_chroma_offset <= `YCC_RST_C_OFS;
      blue_chroma_offset <= `YCC_RST_C_OFS;
      luma_upper_limit <= `YCC_RST_MAX;
      luma_lower_limit <= `YCC_RST_MIN;
      chroma_upper_limit <= `YCC_RST_MAX;
      chroma_lower_limit <= `YCC_RST_MIN;
    end
    else if (wr_take & ~pslverr)
    begin
      case (paddr)
        `YCC_OFF_CTRL: ctrl_enable_reg <= pwdata[`YCC_CTRL_ENABLE];
        `YCC_OFF_RED_W: luma_red_weight <= pwdata[CW-1:0];
        `YCC_OFF_BLUE_W: luma_blue_weight <= pwdata[CW-1:0];
        `YCC_OFF_RED_SC: red_diff_scale_reg <= pwdata[CW-1:0];
        `YCC_OFF_BLUE_SC: blue_diff_scale_reg <= pwdata[CW-1:0];
        `YCC_OFF_Y_OFS: luma_offset <= pwdata[OW-1:0];
        `YCC_OFF_CR_OFS: red_chroma_offset <= pwdata[OW-1:0];
        `YCC_OFF_BLUE_OFS: blue_chroma_offset <= pwdata[OW-1:0];
        `YCC_OFF_Y_MAX: luma_upper_limit <= pwdata[OW-1:0];
        `YCC_OFF_Y_MIN: luma_lower_limit <= pwdata[OW-1:0];
        `YCC_OFF_C_MAX: chroma_upper_limit <= pwdata[OW-1:0];
        `YCC_OFF_C_MIN: chroma_lower_limit <= pwdata[OW-1:0];
        default: ctrl_enable_reg <= ctrl_enable_reg;
      endcase
    end
  end

  // ******************************************************
  // Stream handshake
  // ******************************************************
  wire advance;
  wire s_take;
  reg st1_valid_reg;
  reg st1_sof_reg;
  reg st1_eol_reg;

  assign advance = ~m_valid | m_ready;
  // Ready is not registered: a registered ready would need a skid
  // stage, which the pipe does not carry
  assign s_ready = advance & ctrl_enable_reg;
  assign s_take = s_valid & s_ready;
  assign pipe_busy = st1_valid_reg | m_valid;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_count_reg <= 16'h0000;
    else if (s_take & s_sof)
      frame_count_reg <= frame_count_reg + 16'h0001;
  end

  // ******************************************************
  // Stage 1: intermediate luma
  // ******************************************************
  wire signed [IW+1:0] red_less_green;
  wire signed [IW+1:0] blue_less_green;
  wire signed [IW+CW+2:0] weight_sum;
  wire signed [IW+CW+2:0] weight_rnd;
  wire signed [YW-1:0] yraw_next;
  reg signed [YW-1:0] yraw_reg;
  reg [IW-1:0] st1_red_reg;
  reg [IW-1:0] st1_blue_reg;

  assign red_less_green = $signed({2'b00, s_red}) - $signed({2'b00, s_green});
  assign blue_less_green = $signed({2'b00, s_blue}) - $signed({2'b00, s_green});
  assign weight_sum = $signed({1'b0, luma_red_weight}) * red_less_green
                    + $signed({1'b0, luma_blue_weight}) * blue_less_green;
  // round to product width minus two
  assign weight_rnd = (weight_sum + $signed({{(IW+CW+2-SH1){1'b0}},
                       1'b1, {(SH1-1){1'b0}}})) >>> SH1;
  assign yraw_next = weight_rnd[YW-1:0]
                   + $signed({{(YW-IW-YF){1'b0}}, s_green, {YF{1'b0}}});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st1_valid_reg <= 1'b0;
      st1_sof_reg <= 1'b0;
      st1_eol_reg <= 1'b0;
      yraw_reg <= {YW{1'b0}};
      st1_red_reg <= {IW{1'b0}};
      st1_blue_reg <= {IW{1'b0}};
    end
    else if (advance)
    begin
      // one pixel out per pixel in
      st1_valid_reg <= s_take;
      st1_sof_reg <= s_sof;
      st1_eol_reg <= s_eol;
      yraw_reg <= yraw_next;
      st1_red_reg <= s_red;
      st1_blue_reg <= s_blue;
    end
  end

  // ******************************************************
  // Stage 2: chroma, rounding, offset and limiting
  // ******************************************************
  localparam PW = CW + YW + 2;
  // Channel 0 luma, 1 red chroma, 2 blue chroma
  wire signed [YW:0] red_less_y;
  wire signed [YW:0] blue_less_y;
  wire signed [PW-1:0] red_prod;
  wire signed [PW-1:0] blue_prod;
  wire signed [3*PW-1:0] raw_all;
  wire [3*OW-1:0] ofs_all;
  wire [3*OW-1:0] max_all;
  wire [3*OW-1:0] min_all;
  wire [3*OW-1:0] res_all;

  assign red_less_y = $signed({1'b0, st1_red_reg, {YF{1'b0}}}) - yraw_reg;
  assign blue_less_y = $signed({1'b0, st1_blue_reg, {YF{1'b0}}}) - yraw_reg;
  assign red_prod = $signed({1'b0, red_diff_scale_reg}) * red_less_y;
  assign blue_prod = $signed({1'b0, blue_diff_scale_reg}) * blue_less_y;
  // Luma carries the coefficient fraction too so all share one shift
  assign raw_all = {blue_prod, red_prod,
                    {{(PW-YW-CF){yraw_reg[YW-1]}}, yraw_reg, {CF{1'b0}}}};
  assign ofs_all = {blue_chroma_offset, red_chroma_offset, luma_offset};
  assign max_all = {chroma_upper_limit, chroma_upper_limit,
                    luma_upper_limit};
  assign min_all = {chroma_lower_limit, chroma_lower_limit,
                    luma_lower_limit};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1)
    begin : g_chan
      wire signed [PW-1:0] raw;
      wire signed [PW-1:0] rnd;
      wire signed [OW+2:0] sum;
      wire over;
      wire under;
      assign raw = raw_all[ch*PW +: PW];
      assign rnd = (raw + $signed({{(PW-SH2){1'b0}}, 1'b1,
                    {(SH2-1){1'b0}}})) >>> SH2;
      assign sum = rnd[OW+2:0] + $signed({3'b000, ofs_all[ch*OW +: OW]});
      // saturate only when built with clipping
      assign over = (HAS_CLIPPING != 0) &&
                    (sum > $signed({3'b000, max_all[ch*OW +: OW]}));
      // lower bound only when built with clamping
      assign under = (HAS_CLAMPING != 0) &&
                     (sum < $signed({3'b000, min_all[ch*OW +: OW]}));
      // otherwise low bits wrap on overflow
      assign res_all[ch*OW +: OW] = over ? max_all[ch*OW +: OW] :
                                    under ? min_all[ch*OW +: OW] :
                                    sum[OW-1:0];
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_valid <= 1'b0;
      m_sof <= 1'b0;
      m_eol <= 1'b0;
      m_luma <= {OW{1'b0}};
      m_red_chroma <= {OW{1'b0}};
      m_blue_chroma <= {OW{1'b0}};
    end
    else if (advance)
    begin
      m_valid <= st1_valid_reg;
      m_sof <= st1_sof_reg;
      m_eol <= st1_eol_reg;
      m_luma <= res_all[OW-1:0];
      m_red_chroma <= res_all[2*OW-1:OW];
      m_blue_chroma <= res_all[3*OW-1:2*OW];
    end
  end

endmodule // ycc_matrix

// *** ycc_matrix_assertions.sv ***
// Port checks of the colour matrix, bound to its top module
`include "ycc_defines.vh"
module ycc_matrix_assertions (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Streams
  input wire s_valid,
  input wire s_ready,
  input wire s_sof,
  input wire s_eol,
  input wire m_valid,
  input wire m_ready,
  input wire m_sof,
  input wire m_eol,
  input wire [`YCC_OUT_W-1:0] m_luma,
  input wire [`YCC_OUT_W-1:0] m_red_chroma,
  input wire [`YCC_OUT_W-1:0] m_blue_chroma
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] occ_reg;
  wire take = s_valid && s_ready;
  wire give = m_valid && m_ready;
  default clocking ck @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Pixels in flight, two stages at most
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      occ_reg <= 3'h0;
    else
      occ_reg <= occ_reg + {2'h0, take} - {2'h0, give};
  end
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access cycle");
  AST_UNMAPPED: assert property (
    psel && !penable && paddr > 12'h030 |=> pslverr)
    else $error("unmapped address not refused");
  AST_ERR_READ_ZERO: assert property (
    pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_HOLD: assert property (m_valid && !m_ready |=> m_valid
    && $stable({m_sof, m_eol, m_luma, m_red_chroma, m_blue_chroma}))
    else $error("stalled pixel changed");
  AST_STALL_BLOCKS: assert property (m_valid && !m_ready |-> !s_ready)
    else $error("input open while output stalled");
  AST_LATENCY: assert property (
    (take && m_ready) ##1 m_ready |=> m_valid
    && {m_sof, m_eol} == $past({s_sof, s_eol}, 2))
    else $error("pixel not out two cycles after take");
  AST_NO_GHOST: assert property (m_valid |-> occ_reg != 3'h0)
    else $error("output pixel without input pixel");
  AST_DEPTH: assert property (occ_reg <= 3'h2)
    else $error("more pixels in flight than stages");
endmodule // ycc_matrix_assertions

bind ycc_matrix ycc_matrix_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
  .s_sof(s_sof), .s_eol(s_eol), .m_valid(m_valid), .m_ready(m_ready),
  .m_sof(m_sof), .m_eol(m_eol), .m_luma(m_luma),
  .m_red_chroma(m_red_chroma), .m_blue_chroma(m_blue_chroma)
);

// *** ycc_sink_model.sv ***
// Downstream stream sink that can stall
module ycc_sink_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control and stream
  input wire slow,
  input wire m_valid,
  output logic m_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 2'h0;
      m_ready <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + {1'b0, m_valid};
      m_ready <= !slow || (cnt_reg == 2'h3);
    end
  end
endmodule // ycc_sink_model

// *** tb.sv ***
// Self-checking bench of the colour matrix
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic s_valid = 1'b0;
  logic s_sof = 1'b0;
  logic s_eol = 1'b0;
  logic [7:0] s_red = 8'h00;
  logic [7:0] s_green = 8'h00;
  logic [7:0] s_blue = 8'h00;
  logic slow = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, s_ready, m_valid, m_ready, m_sof, m_eol;
  wire [7:0] m_luma, m_red_chroma, m_blue_chroma;
  wire w_sof, w_eol;
  wire [7:0] w_luma, w_red_chroma, w_blue_chroma;
  wire [31:0] got = {6'h0, m_sof, m_eol, m_luma, m_red_chroma, m_blue_chroma};
  wire [31:0] got_w = {6'h0, w_sof, w_eol, w_luma, w_red_chroma,
    w_blue_chroma};
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] cfg [13];
  logic [31:0] exp_q [$];
  logic [31:0] exp_w [$];
  logic [31:0] rst_tab [13] = '{32'h1, 32'h0, 32'h04C8C, 32'h01D2F,
    32'h0B688, 32'h09063, 32'h10, 32'h80, 32'h80, 32'hF0, 32'h10,
    32'hF0, 32'h10};
  logic [23:0] bars [8] = '{24'hFFFFFF, 24'hFFFF00, 24'h00FFFF,
    24'h00FF00, 24'hFF00FF, 24'hFF0000, 24'h0000FF, 24'h000000};
  real pcc [4] = '{0.713, 0.7295, 0.6350, 1.5};
  real pcd [4] = '{0.564, 0.564, 0.5389, 1.5};
  int pmax [4] = '{240, 235, 240, 240};

  always #10 pclk = ~pclk;

  ycc_matrix i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .s_valid(s_valid),
    .s_ready(s_ready), .s_sof(s_sof), .s_eol(s_eol), .s_red(s_red),
    .s_green(s_green), .s_blue(s_blue), .m_valid(m_valid),
    .m_ready(m_ready), .m_sof(m_sof), .m_eol(m_eol), .m_luma(m_luma),
    .m_red_chroma(m_red_chroma), .m_blue_chroma(m_blue_chroma)
  );
  ycc_sink_model i_sink (.pclk(pclk), .presetn(presetn), .slow(slow),
    .m_valid(m_valid), .m_ready(m_ready));
  // Same stream and registers, built without clipping or clamping
  ycc_matrix #(.HAS_CLIPPING(0), .HAS_CLAMPING(0)) i_wrap (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .s_valid(s_valid), .s_ready(),
    .s_sof(s_sof), .s_eol(s_eol), .s_red(s_red), .s_green(s_green),
    .s_blue(s_blue), .m_valid(), .m_ready(m_ready), .m_sof(w_sof),
    .m_eol(w_eol), .m_luma(w_luma), .m_red_chroma(w_red_chroma),
    .m_blue_chroma(w_blue_chroma)
  );

  // ****************************************
  // Bus cycles, model and comparison
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
      input logic ee);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask

  task automatic wr(input int i, input logic [31:0] v);
    apb(1'b1, 12'(i * 4), v, rd, er);
    cfg[i] = v;
  endtask

  function automatic logic [31:0] enc(input real x);
    return $rtoi(x * 65537.0 + 0.5);
  endfunction

  function automatic logic [7:0] lim(input int v, input int hi, input int lo);
    if (v > hi)
      return hi[7:0];
    if (v < lo)
      return lo[7:0];
    return v[7:0];
  endfunction

  // Intermediate luma keeps six fraction bits, as the datapath does
  function automatic logic [31:0] mdl(input int r, input int g, input int b,
      input logic sf, input logic el, input bit wrp);
    longint s;
    longint yr;
    int y;
    int cr;
    int cb;
    s = longint'(cfg[2]) * (r - g) + longint'(cfg[3]) * (b - g);
    yr = g * 64 + ((s + 512) >>> 10);
    y = int'((yr + 32) >>> 6) + int'(cfg[6]);
    cr = int'((longint'(cfg[4]) * (r * 64 - yr) + 2097152) >>> 22)
      + int'(cfg[7]);
    cb = int'((longint'(cfg[5]) * (b * 64 - yr) + 2097152) >>> 22)
      + int'(cfg[8]);
    // Without limiting only the low eight bits of each sum survive
    if (wrp)
      return {6'h0, sf, el, y[7:0], cr[7:0], cb[7:0]};
    return {6'h0, sf, el, lim(y, cfg[9], cfg[10]),
      lim(cr, cfg[11], cfg[12]),
      lim(cb, cfg[11], cfg[12])};
  endfunction

  task automatic send(input logic [23:0] p, input logic sf, input logic el);
    s_valid <= 1'b1;
    {s_red, s_green, s_blue} <= p;
    s_sof <= sf;
    s_eol <= el;
    exp_q.push_back(mdl(p[23:16], p[15:8], p[7:0], sf, el, 1'b0));
    exp_w.push_back(mdl(p[23:16], p[15:8], p[7:0], sf, el, 1'b1));
    do
      @(posedge pclk);
    while (s_ready !== 1'b1);
  endtask

  // Idle data lines show the inverse so a stale pixel cannot match
  task automatic burst();
    for (int k = 0; k < 8; k++)
      send(bars[k], k == 0, k == 7);
    s_valid <= 1'b0;
    {s_red, s_green, s_blue} <= ~{s_red, s_green, s_blue};
    for (int k = 0; k < 200 && exp_q.size() != 0; k++)
      @(posedge pclk);
    chk(exp_q.size(), 32'h0);
  endtask

  always @(posedge pclk)
  begin
    if (m_valid === 1'b1 && m_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(got, exp_q.pop_front());
      if (exp_w.size() != 0)
        chk(got_w, exp_w.pop_front());
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Test sequence and watchdog
  // ****************************************
  initial
  begin
    for (int i = 0; i < 13; i++)
      cfg[i] = rst_tab[i];
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++)
      rdchk(12'(i * 4), rst_tab[i], 1'b0);
    rdchk(12'h034, 32'h0, 1'b1);
    for (int i = 2; i < 13; i++)
    begin
      wr(i, 32'hFFFF_FFFF);
      rdchk(12'(i * 4), i < 6 ? 32'h1FFFF : 32'hFF, 1'b0);
      wr(i, rst_tab[i]);
    end
    wr(1, 32'hFFFF_FFFF);
    rdchk(12'h004, 32'h0, 1'b0);
    burst();
    for (int p = 0; p < 4; p++)
    begin
      slow <= p[0];
      wr(4, enc(pcc[p]));
      wr(5, enc(pcd[p]));
      wr(9, pmax[p]);
      wr(11, pmax[p]);
      wr(6, 32'h1 << (8 - 4));
      wr(7, 32'h1 << (8 - 1));
      burst();
    end
    wr(0, 32'h0);
    s_valid <= 1'b1;
    repeat (4) @(posedge pclk) chk(s_ready, 32'h0);
    s_valid <= 1'b0;
    wr(0, 32'h1);
    rdchk(12'h004, 32'h0005_0000, 1'b0);
    end_of_test();
  end

  initial
  begin
    #400000;
    miscompares++;
    end_of_test();
  end
endmodule // tb
